// file: hdl/wwdt_map.svh
`ifndef WWDT_MAP_SVH
`define WWDT_MAP_SVH

// ==========================================================================
// Register offsets
`define WWDT_OFF_CTRL0   8'h00
`define WWDT_OFF_CTRL1   8'h04
`define WWDT_OFF_STAT    8'h08
`define WWDT_OFF_COUNT   8'h0c

// ==========================================================================
// Field positions
`define WWDT_C0_SEN      0
`define WWDT_C0_PS_LSB   1
`define WWDT_C1_WIN_LSB  0
`define WWDT_C1_CS_LSB   4
`define WWDT_ST_WV       0
`define WWDT_ST_WATCHDOG_RESET_FLAG     1
`define WWDT_ST_TO       2
`define WWDT_ST_PD       3
`define WWDT_ST_ARM      4
`define WWDT_ST_OPEN     5

// ==========================================================================
// Reset values and codes
`define WWDT_PS_RST      5'h0b
`define WWDT_PS_MAX      5'h12
`define WWDT_PS_RUNTIME  5'h1f
`define WWDT_CFG_RUNTIME 3'h7
`define WWDT_CS_LF       3'h0
`define WWDT_CS_MF       3'h1
`define WWDT_WIN_FULL    3'h7
`define WWDT_TAP_BASE    5'h05
`define WWDT_WIN_SHIFT   5'h02
`endif

// file: hdl/wwdt_pkg.sv
package wwdt_pkg;
  // Enable mode, ordered so its codes match the configuration bits
  typedef enum logic [1:0] {
    WWDT_OFF,
    WWDT_SOFT,
    WWDT_AWAKE,
    WWDT_ALWAYS
  } wwdt_mode_t;
  typedef enum logic [1:0] {
    WWDT_OKAY   = 2'h0,
    WWDT_SLVERR = 2'h2
  } wwdt_resp_t;
endpackage

// file: hdl/wwdt_top.sv
`include "wwdt_map.svh"

module wwdt_top
  import wwdt_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic        POR,
  // Configuration words
  input  wire logic [1:0]  ENABLE_MODE_CONFIG,
  input  wire logic [4:0]  CONFIG_PRESCALE,
  input  wire logic [2:0]  CONFIG_WINDOW_SIZE,
  input  wire logic [2:0]  CONFIG_CLOCK_SOURCE,
  // Time bases and core events
  input  wire logic        LOW_FREQ_INTERNAL_OSC,
  input  wire logic        MID_FREQ_INTERNAL_OSC,
  input  wire logic        SLEEP,
  input  wire logic        OSCILLATOR_STARTUP_TIMER,
  input  wire logic        WATCHDOG_CLEAR_INSTRUCTION,
  // System outputs
  output logic             WDT_RESET,
  output logic             WAKE,
  output logic             TIMEOUT_STATUS_FLAG,
  output logic             POWERDOWN_STATUS_FLAG,
  output logic             WINDOW_VIOLATION_FLAG,
  output logic             WATCHDOG_RESET_FLAG,
  // AXI4-Lite write
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY
);

  // ========================================================================
  // Declarations
  logic [17:0] pre;
  logic [4:0]  ovf;
  logic [22:0] full;
  logic [4:0]  ps_reg;
  logic        software_watchdog_switch;
  logic [2:0]  cs_reg;
  logic [2:0]  win_reg;
  logic        armed;
  logic        sleep_q;
  logic [7:0]  aw_addr;
  logic [7:0]  w_byte;
  logic        aw_held;
  logic        w_held;
  logic [4:0]  ps_eff;
  logic [4:0]  sel;
  logic [2:0]  cs_eff;
  logic [2:0]  win_eff;
  logic        tick;
  logic        active;
  logic        windowed;
  logic [23:0] span;
  logic        last;
  logic [2:0]  pos;
  logic        win_open;
  logic        viol;
  logic        clr_ok;
  logic        to_evt;
  logic        wr_go;
  logic        wr_ctrl;
  logic        clr_any;
  logic        rd_go;
  logic [31:0] rd_val;
  wwdt_mode_t  mode;

  assign full = {ovf, pre};

  // ========================================================================
  // Effective settings
  always_comb begin
    mode = wwdt_mode_t'(ENABLE_MODE_CONFIG);
    ps_eff = (CONFIG_PRESCALE == `WWDT_PS_RUNTIME) ? ps_reg
                                                   : CONFIG_PRESCALE;
    sel = (ps_eff > `WWDT_PS_MAX) ? 5'h00 : ps_eff;
    cs_eff = (CONFIG_CLOCK_SOURCE == `WWDT_CFG_RUNTIME) ? cs_reg
                                                        : CONFIG_CLOCK_SOURCE;
    win_eff = (CONFIG_WINDOW_SIZE == `WWDT_CFG_RUNTIME) ? win_reg
                                                        : CONFIG_WINDOW_SIZE;
    // Reserved clock codes fall back to the low oscillator
    tick = (cs_eff == `WWDT_CS_MF) ? MID_FREQ_INTERNAL_OSC
                                   : LOW_FREQ_INTERNAL_OSC;
    unique case (mode)
      WWDT_ALWAYS: active = 1'b1;
      WWDT_AWAKE:  active = !SLEEP;
      WWDT_SOFT:   active = software_watchdog_switch;
      WWDT_OFF:    active = 1'b0;
    endcase
  end

  // ========================================================================
  // Tap and window compare
  always_comb begin
    span = 24'h000001 << (sel + `WWDT_TAP_BASE);
    last = (full == span[22:0] - 23'h000001);
    pos = 3'(full >> (sel + `WWDT_WIN_SHIFT));
    windowed = (win_eff != `WWDT_WIN_FULL);
    // Closed for the first (7 - code) eighths of the period
    win_open = !windowed || (pos >= (3'h7 - win_eff));
  end

  assign viol = WATCHDOG_CLEAR_INSTRUCTION && active && windowed &&
                (!armed || !win_open);
  assign clr_ok = WATCHDOG_CLEAR_INSTRUCTION && active && !viol;
  assign to_evt = tick && active && last && !OSCILLATOR_STARTUP_TIMER;
  assign wr_go = aw_held && w_held && !BVALID;
  assign wr_ctrl = wr_go && (aw_addr == `WWDT_OFF_CTRL0 ||
                             aw_addr == `WWDT_OFF_CTRL1);
  assign rd_go = ARVALID && ARREADY;
  // A write to either control register clears the count, prescaler stage included
  assign clr_any = !active || OSCILLATOR_STARTUP_TIMER ||
                   (SLEEP != sleep_q) || clr_ok || viol || wr_ctrl;

  // ========================================================================
  // Prescaler and overflow counter
  always_ff @(posedge MCLK) begin
    if (SRST || clr_any) begin
      pre <= '0;
      ovf <= '0;
    end else if (tick && active) begin
      // Keeps running in Sleep when enabled there
      {ovf, pre} <= last ? 23'h000000 : full + 23'h000001;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= SLEEP;
    end
  end

  // ========================================================================
  // Arming
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      armed <= 1'b0;
    end else begin
      if (WATCHDOG_CLEAR_INSTRUCTION) begin
        armed <= 1'b0;
      end
      if (rd_go && {ARADDR[7:2], 2'b00} == `WWDT_OFF_CTRL0) begin
        armed <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Reset, wake and status
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      WDT_RESET <= 1'b0;
      WAKE <= 1'b0;
    end else begin
      WDT_RESET <= viol || (to_evt && !SLEEP);
      WAKE <= to_evt && SLEEP;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      TIMEOUT_STATUS_FLAG <= 1'b1;
      POWERDOWN_STATUS_FLAG <= 1'b1;
    end else if (to_evt && SLEEP) begin
      TIMEOUT_STATUS_FLAG <= 1'b0;
      POWERDOWN_STATUS_FLAG <= 1'b0;
    end else if (SLEEP && !sleep_q) begin
      TIMEOUT_STATUS_FLAG <= 1'b1;
      POWERDOWN_STATUS_FLAG <= 1'b0;
    end else if (clr_ok) begin
      TIMEOUT_STATUS_FLAG <= 1'b1;
      POWERDOWN_STATUS_FLAG <= 1'b1;
    end
  end

  // Survive the system reset they cause; power-on or a firmware write of 1 sets them
  always_ff @(posedge MCLK) begin
    if (POR) begin
      WINDOW_VIOLATION_FLAG <= 1'b1;
      WATCHDOG_RESET_FLAG <= 1'b1;
    end else begin
      if (wr_go && aw_addr == `WWDT_OFF_STAT) begin
        if (w_byte[`WWDT_ST_WV]) begin
          WINDOW_VIOLATION_FLAG <= 1'b1;
        end
        if (w_byte[`WWDT_ST_WATCHDOG_RESET_FLAG]) begin
          WATCHDOG_RESET_FLAG <= 1'b1;
        end
      end
      // Hardware event wins over a firmware set in the same cycle
      if (viol) begin
        WINDOW_VIOLATION_FLAG <= 1'b0;
      end
      if (viol || to_evt) begin
        WATCHDOG_RESET_FLAG <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Software registers
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ps_reg <= `WWDT_PS_RST;
      software_watchdog_switch <= 1'b0;
      cs_reg <= `WWDT_CS_LF;
      win_reg <= `WWDT_WIN_FULL;
    end else if (wr_go) begin
      if (aw_addr == `WWDT_OFF_CTRL0) begin
        ps_reg <= w_byte[`WWDT_C0_PS_LSB +: 5];
        software_watchdog_switch <= w_byte[`WWDT_C0_SEN];
      end
      if (aw_addr == `WWDT_OFF_CTRL1) begin
        cs_reg <= w_byte[`WWDT_C1_CS_LSB +: 3];
        win_reg <= w_byte[`WWDT_C1_WIN_LSB +: 3];
      end
    end
  end

  // ========================================================================
  // AXI4-Lite write channel
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_byte <= 8'h00;
      BVALID <= 1'b0;
      BRESP <= WWDT_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        AWREADY <= 1'b0;
        aw_held <= 1'b1;
        aw_addr <= {AWADDR[7:2], 2'b00};
      end
      if (WVALID && WREADY) begin
        WREADY <= 1'b0;
        w_held <= 1'b1;
        // Registers hold one byte; other lanes are ignored
        w_byte <= WSTRB[0] ? WDATA[7:0] : 8'h00;
      end
      if (wr_go) begin
        BVALID <= 1'b1;
        BRESP <= (aw_addr == `WWDT_OFF_CTRL0 ||
                  aw_addr == `WWDT_OFF_CTRL1 ||
                  aw_addr == `WWDT_OFF_STAT) ? WWDT_OKAY : WWDT_SLVERR;
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  // ========================================================================
  // AXI4-Lite read channel
  always_comb begin
    rd_val = 32'h00000000;
    unique case ({ARADDR[7:2], 2'b00})
      `WWDT_OFF_CTRL0: rd_val = {26'h0, ps_eff, software_watchdog_switch};
      `WWDT_OFF_CTRL1: rd_val = {25'h0, cs_eff, 1'b0, win_eff};
      `WWDT_OFF_STAT:  rd_val = {26'h0, win_open, armed,
                                 POWERDOWN_STATUS_FLAG, TIMEOUT_STATUS_FLAG,
                                 WATCHDOG_RESET_FLAG, WINDOW_VIOLATION_FLAG};
      `WWDT_OFF_COUNT: rd_val = {9'h000, full};
      default:         rd_val = 32'h00000000;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= WWDT_OKAY;
    end else begin
      if (rd_go) begin
        ARREADY <= 1'b0;
        RVALID <= 1'b1;
        RDATA <= rd_val;
        RRESP <= (ARADDR[7:4] == 4'h0) ? WWDT_OKAY : WWDT_SLVERR;
      end
      if (RVALID && RREADY) begin
        RVALID <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  chk_awake_timeout: assert property (
    to_evt && !SLEEP |=> WDT_RESET && !WAKE)
    else $error("awake time-out gave no reset");
  chk_sleep_wake: assert property (
    to_evt && SLEEP |=> WAKE && !WDT_RESET && !TIMEOUT_STATUS_FLAG)
    else $error("sleep time-out did not wake");
  chk_mode_always: assert property (
    ENABLE_MODE_CONFIG == 2'h3 |-> active)
    else $error("mode 11 not active");
  chk_mode_sleep_off: assert property (
    ENABLE_MODE_CONFIG == 2'h2 && SLEEP |=> full == 23'h0 && !WAKE)
    else $error("mode 10 counted in sleep");
  chk_mode_soft: assert property (
    ENABLE_MODE_CONFIG == 2'h1 && !software_watchdog_switch |=> full == 23'h0 && !WDT_RESET)
    else $error("mode 01 ignores switch");
  chk_mode_off_hold: assert property (
    (ENABLE_MODE_CONFIG == 2'h0) [*2] |-> full == 23'h0 && !WDT_RESET)
    else $error("mode 00 counted");
  chk_violation_flag: assert property (
    viol |=> WDT_RESET && !WINDOW_VIOLATION_FLAG && !armed)
    else $error("violation not handled");
  chk_unarmed_clear: assert property (
    WATCHDOG_CLEAR_INSTRUCTION && active && windowed && !armed
      |=> WDT_RESET)
    else $error("unarmed clear accepted");
  chk_ost_hold: assert property (
    OSCILLATOR_STARTUP_TIMER |=> full == 23'h0)
    else $error("count moved during start-up");
  chk_ctrl_write: assert property (
    wr_ctrl |=> full == 23'h0 && BVALID)
    else $error("control write kept count");
  chk_tap_reserved: assert property (
    ps_eff > 5'h12 |-> span == 24'h000020)
    else $error("reserved code not minimum");

  cov_awake_reset: cover property (to_evt && !SLEEP ##1 WDT_RESET);
  cov_sleep_wake: cover property (SLEEP && to_evt ##1 WAKE);
  cov_armed_clear: cover property (armed && windowed && clr_ok);
  cov_violation: cover property (viol);

endmodule

// file: bench/wwdt_core_model.sv
module wwdt_core_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Bench requests
  input  wire logic lf_en,
  input  wire logic mf_en,
  input  wire logic clr_go,
  // Towards the watchdog
  output logic      lf_tick,
  output logic      mf_tick,
  output logic      clr_pulse
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] phase;

  // ==========================================================================
  // Oscillators
  // Slow time bases shrunk to one tick per four clocks to keep runs short
  always_ff @(posedge clk) begin
    if (rst || !(lf_en || mf_en)) phase <= 2'h0;
    else phase <= phase + 2'h1;
  end
  assign lf_tick = lf_en && (phase == 2'h0);
  assign mf_tick = mf_en && (phase == 2'h0);

  // ==========================================================================
  // Clear command
  // Core issues the command only; the arming read is the bench's duty
  always_ff @(posedge clk) begin
    clr_pulse <= clr_go && !rst;
  end
endmodule

// file: bench/tb_windowed_watchdog_timer.sv
`define CHK(nm, ex, got) \
  begin check_count++; if ((got) !== (ex)) begin err_count++; \
  $display("ERROR %s exp %0h got %0h", nm, ex, got); end end

module tb_windowed_watchdog_timer
  import wwdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        MCLK = 1'b0;
  logic        SRST, POR, SLEEP, OSCILLATOR_STARTUP_TIMER;
  logic [1:0]  ENABLE_MODE_CONFIG;
  logic [4:0]  CONFIG_PRESCALE;
  logic [2:0]  CONFIG_WINDOW_SIZE, CONFIG_CLOCK_SOURCE;
  logic        LOW_FREQ_INTERNAL_OSC, MID_FREQ_INTERNAL_OSC;
  logic        WATCHDOG_CLEAR_INSTRUCTION;
  logic        WDT_RESET, WAKE, TIMEOUT_STATUS_FLAG, POWERDOWN_STATUS_FLAG;
  logic        WINDOW_VIOLATION_FLAG, WATCHDOG_RESET_FLAG;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rdat;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, resp;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY;
  logic        lf_en, mf_en, clr_go;
  int          err_count, check_count, rst_seen, wake_seen;

  wwdt_top i_wwdt_top (
    .MCLK                       (MCLK),
    .SRST                       (SRST),
    .POR                        (POR),
    .ENABLE_MODE_CONFIG         (ENABLE_MODE_CONFIG),
    .CONFIG_PRESCALE            (CONFIG_PRESCALE),
    .CONFIG_WINDOW_SIZE         (CONFIG_WINDOW_SIZE),
    .CONFIG_CLOCK_SOURCE        (CONFIG_CLOCK_SOURCE),
    .LOW_FREQ_INTERNAL_OSC      (LOW_FREQ_INTERNAL_OSC),
    .MID_FREQ_INTERNAL_OSC      (MID_FREQ_INTERNAL_OSC),
    .SLEEP                      (SLEEP),
    .OSCILLATOR_STARTUP_TIMER   (OSCILLATOR_STARTUP_TIMER),
    .WATCHDOG_CLEAR_INSTRUCTION (WATCHDOG_CLEAR_INSTRUCTION),
    .WDT_RESET                  (WDT_RESET),
    .WAKE                       (WAKE),
    .TIMEOUT_STATUS_FLAG        (TIMEOUT_STATUS_FLAG),
    .POWERDOWN_STATUS_FLAG      (POWERDOWN_STATUS_FLAG),
    .WINDOW_VIOLATION_FLAG      (WINDOW_VIOLATION_FLAG),
    .WATCHDOG_RESET_FLAG        (WATCHDOG_RESET_FLAG),
    .AWADDR                     (AWADDR),
    .AWVALID                    (AWVALID),
    .AWREADY                    (AWREADY),
    .WDATA                      (WDATA),
    .WSTRB                      (WSTRB),
    .WVALID                     (WVALID),
    .WREADY                     (WREADY),
    .BRESP                      (BRESP),
    .BVALID                     (BVALID),
    .BREADY                     (BREADY),
    .ARADDR                     (ARADDR),
    .ARVALID                    (ARVALID),
    .ARREADY                    (ARREADY),
    .RDATA                      (RDATA),
    .RRESP                      (RRESP),
    .RVALID                     (RVALID),
    .RREADY                     (RREADY)
  );

  wwdt_core_model i_wwdt_core_model (
    .clk       (MCLK),
    .rst       (SRST),
    .lf_en     (lf_en),
    .mf_en     (mf_en),
    .clr_go    (clr_go),
    .lf_tick   (LOW_FREQ_INTERNAL_OSC),
    .mf_tick   (MID_FREQ_INTERNAL_OSC),
    .clr_pulse (WATCHDOG_CLEAR_INSTRUCTION)
  );

  always #2 MCLK = ~MCLK;

  always @(posedge MCLK) begin
    if (WDT_RESET === 1'b1) rst_seen++;
    if (WAKE === 1'b1) wake_seen++;
  end

  // ==========================================================================
  // Bus and stimulus helpers
  // Waits as long as it takes; only the watchdog ends a hung transfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge MCLK);
    AWADDR  <= a;
    WDATA   <= d;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    do begin
      @(posedge MCLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    r = BRESP;
    BREADY <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge MCLK);
    ARADDR  <= a;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    do begin
      @(posedge MCLK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask

  task automatic do_reset(input logic [1:0] m, input logic [4:0] ps,
                          input logic [2:0] ws, input logic [2:0] cs);
    @(posedge MCLK);
    SRST <= 1'b1;
    POR <= 1'b1;
    ENABLE_MODE_CONFIG <= m;
    CONFIG_PRESCALE <= ps;
    CONFIG_WINDOW_SIZE <= ws;
    CONFIG_CLOCK_SOURCE <= cs;
    SLEEP <= 1'b0;
    OSCILLATOR_STARTUP_TIMER <= 1'b0;
    repeat (10) @(posedge MCLK);
    SRST <= 1'b0;
    POR <= 1'b0;
    rst_seen = 0;
    wake_seen = 0;
  endtask

  // Four clocks per tick, then settle so a late pulse is counted
  task automatic ticks(input logic mf, input int n);
    @(posedge MCLK);
    if (mf) mf_en <= 1'b1;
    else lf_en <= 1'b1;
    repeat (4 * n) @(posedge MCLK);
    lf_en <= 1'b0;
    mf_en <= 1'b0;
    repeat (3) @(posedge MCLK);
  endtask

  task automatic clear(input logic arm);
    if (arm) rd(8'h00, rdat, resp);
    @(posedge MCLK);
    clr_go <= 1'b1;
    @(posedge MCLK);
    clr_go <= 1'b0;
    repeat (3) @(posedge MCLK);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    do_reset(2'h3, 5'h1f, 3'h7, 3'h7);
    rd(8'h00, rdat, resp);
    `CHK("ctrl0 reset", 32'h16, rdat)
    rd(8'h04, rdat, resp);
    `CHK("ctrl1 reset", 32'h07, rdat)
    rd(8'h10, rdat, resp);
    `CHK("unmapped rresp", WWDT_SLVERR, resp)
    wr(8'h0c, 32'h1, resp);
    `CHK("count bresp", WWDT_SLVERR, resp)
    wr(8'h00, 32'h0, resp);
    ticks(1'b0, 31);
    `CHK("early reset", 0, rst_seen)
    ticks(1'b0, 1);
    `CHK("timeout reset", 1, rst_seen)
    do_reset(2'h3, 5'h03, 3'h7, 3'h7);
    wr(8'h00, 32'h0, resp);
    rd(8'h00, rdat, resp);
    `CHK("ctrl0 fixed", 32'h06, rdat)
    $display("test regs done");
  endtask

  task automatic t_period();
    logic [4:0] code [3] = '{5'h00, 5'h01, 5'h13};
    int per [3] = '{32, 64, 32};
    foreach (code[i]) begin
      do_reset(2'h3, code[i], 3'h7, 3'h0);
      ticks(1'b0, per[i] - 1);
      `CHK("no reset yet", 0, rst_seen)
      ticks(1'b0, 1);
      `CHK("period reset", 1, rst_seen)
      `CHK("watchdog_reset_flag flag", 1'b0, WATCHDOG_RESET_FLAG)
    end
    $display("test period done");
  endtask

  task automatic t_modes();
    // Fields: mode, switch, asleep, expect reset, expect wake
    logic [5:0] tab [7] = '{6'b001000, 6'b010000, 6'b011010, 6'b011101,
                            6'b100010, 6'b100100, 6'b110101};
    foreach (tab[i]) begin
      do_reset(tab[i][5:4], 5'h00, 3'h7, 3'h0);
      wr(8'h00, {31'h0, tab[i][3]}, resp);
      SLEEP <= tab[i][2];
      ticks(1'b0, 32);
      `CHK("mode reset", int'(tab[i][1]), rst_seen)
      `CHK("mode wake", int'(tab[i][0]), wake_seen)
      if (tab[i][2]) begin
        `CHK("pd flag", 1'b0, POWERDOWN_STATUS_FLAG)
        `CHK("to flag", ~tab[i][0], TIMEOUT_STATUS_FLAG)
      end
    end
    $display("test modes done");
  endtask

  task automatic t_clears();
    do_reset(2'h3, 5'h00, 3'h7, 3'h7);
    ticks(1'b0, 20);
    wr(8'h04, 32'h7, resp);
    ticks(1'b0, 20);
    `CHK("write clears", 0, rst_seen)
    ticks(1'b0, 12);
    `CHK("after write", 1, rst_seen)
    OSCILLATOR_STARTUP_TIMER <= 1'b1;
    ticks(1'b0, 40);
    `CHK("ost hold", 1, rst_seen)
    OSCILLATOR_STARTUP_TIMER <= 1'b0;
    ticks(1'b0, 20);
    SLEEP <= 1'b1;
    ticks(1'b0, 31);
    `CHK("sleep clears", 0, wake_seen)
    ticks(1'b0, 1);
    `CHK("sleep wake", 1, wake_seen)
    `CHK("sleep no reset", 1, rst_seen)
    SLEEP <= 1'b0;
    wr(8'h04, 32'h17, resp);
    ticks(1'b0, 40);
    `CHK("low osc ignored", 1, rst_seen)
    ticks(1'b1, 32);
    `CHK("mid osc reset", 2, rst_seen)
    $display("test clears done");
  endtask

  task automatic t_window();
    do_reset(2'h3, 5'h00, 3'h7, 3'h0);
    `CHK("wv after por", 1'b1, WINDOW_VIOLATION_FLAG)
    wr(8'h04, 32'h0, resp);
    ticks(1'b0, 29);
    clear(1'b0);
    `CHK("unarmed clear", 1, rst_seen)
    `CHK("wv cleared", 1'b0, WINDOW_VIOLATION_FLAG)
    wr(8'h08, 32'h1, resp);
    `CHK("wv fw set", 1'b1, WINDOW_VIOLATION_FLAG)
    wr(8'h04, 32'h0, resp);
    ticks(1'b0, 29);
    rd(8'h0c, rdat, resp);
    `CHK("count value", 32'h1d, rdat)
    rd(8'h08, rdat, resp);
    `CHK("status word", 32'h2d, rdat)
    clear(1'b1);
    `CHK("open clear", 1, rst_seen)
    ticks(1'b0, 31);
    `CHK("clear restarts", 1, rst_seen)
    wr(8'h04, 32'h0, resp);
    ticks(1'b0, 5);
    clear(1'b1);
    `CHK("closed clear", 2, rst_seen)
    do_reset(2'h3, 5'h00, 3'h0, 3'h0);
    wr(8'h04, 32'h7, resp);
    ticks(1'b0, 5);
    clear(1'b1);
    `CHK("config window", 1, rst_seen)
    $display("test window done");
  endtask

  // ==========================================================================
  // Run control
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    {SRST, POR, SLEEP, OSCILLATOR_STARTUP_TIMER} = 4'hf;
    {lf_en, mf_en, clr_go} = 3'h0;
    ENABLE_MODE_CONFIG = 2'h3;
    CONFIG_PRESCALE = 5'h1f;
    {CONFIG_WINDOW_SIZE, CONFIG_CLOCK_SOURCE} = 6'h3f;
    {AWADDR, ARADDR, WDATA} = 48'h0;
    WSTRB = 4'hf;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h0;
    t_regs();
    t_period();
    t_modes();
    t_clears();
    t_window();
    wrap_up();
  end

  // Tests need some 3200 clocks; allow generous margin
  initial begin
    repeat (40000) @(posedge MCLK);
    err_count++;
    wrap_up();
  end
endmodule
